// >>> event_source_model.sv
// model of the on-chip clock buses, clock pins and input event buses
// assumes one clock; clock bus lines and pins toggle at distinct rates, as do event lines, so picks differ within each group
`timescale 1ns/10ps
module event_source_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // source lines
    output logic [3:0] o_clock_bus,
    output logic o_pin_1,
    output logic o_pin_2,
    output logic [3:0] o_event_bus
);
    logic [7:0] cnt_reg;
    // free-running pattern counter
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) cnt_reg <= 8'h00;
        else cnt_reg <= cnt_reg + 8'h01;
    end
    // distinct patterns among the clock choices and among the event lines
    assign o_clock_bus = cnt_reg[3:0];
    assign o_pin_1 = cnt_reg[4];
    assign o_pin_2 = ~cnt_reg[5];
    assign o_event_bus = cnt_reg[6:3] ^ {3'h0, cnt_reg[0]};
endmodule : event_source_model

// >>> mode_select_sva.sv
// checker for the channel 5 to 9 clock, trigger and mode selection
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module mode_select_sva (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // read channel
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic o_s_axi_rvalid,
    // sources
    input wire logic [3:0] i_clock_bus,
    input wire logic i_ext_clock_pin_1,
    input wire logic i_ext_clock_pin_2,
    input wire logic [3:0] i_event_bus,
    // decoded outputs
    input wire timer_channel_mode_select_pkg::chan_cfg_t [4:0] o_chan_cfg,
    input wire logic [4:0] o_count_clock,
    input wire logic [4:0] o_trigger
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic [3:0] cb_q;
    logic [3:0] ev_q;
    logic p1_q;
    logic p2_q;
    logic [4:0] exp_clk;
    logic [4:0] exp_trg;
    logic bad_mode;
    // source levels one cycle back, as the registered outputs see them
    always_ff @(posedge i_clk) begin
        cb_q <= i_clock_bus;
        ev_q <= i_event_bus;
        p1_q <= i_ext_clock_pin_1;
        p2_q <= i_ext_clock_pin_2;
    end
    // expected selections from the decoded settings
    always_comb begin
        bad_mode = 1'b0;
        for (int k = 0; k < 5; k++) begin
            exp_clk[k] = cb_q[o_chan_cfg[k].clk_bus];
            exp_trg[k] = o_chan_cfg[k].trig_on & ev_q[o_chan_cfg[k].trig_bus];
            if (o_chan_cfg[k].mode == 3'h7) bad_mode = 1'b1;
        end
        if (o_chan_cfg[0].clk_from_pin) exp_clk[0] = p1_q;
        if (o_chan_cfg[1].clk_from_pin) exp_clk[1] = p2_q;
    end
    sequence s_cfg_held;
        $stable(o_chan_cfg) && $past(i_rst_b);
    endsequence
    sequence s_rd_taken;
        i_s_axi_arvalid && o_s_axi_arready;
    endsequence
    AST_CLK_FOLLOW: assert property (s_cfg_held |-> o_count_clock == exp_clk)
        else $error("count clock not the selected source");
    AST_TRG_FOLLOW: assert property (s_cfg_held |-> o_trigger == exp_trg)
        else $error("trigger not the selected event bus");
    AST_NO_PIN: assert property (!(o_chan_cfg[2].clk_from_pin | o_chan_cfg[3].clk_from_pin
        | o_chan_cfg[4].clk_from_pin)) else $error("channel 7 to 9 picked a pin");
    AST_CH5_TRG: assert property (o_chan_cfg[0].trig_on |-> o_chan_cfg[0].trig_bus == 2'h3)
        else $error("channel 5 trigger bus wrong");
    AST_CH6_TRG: assert property (o_chan_cfg[1].trig_on |-> o_chan_cfg[1].trig_bus[1])
        else $error("channel 6 trigger bus wrong");
    AST_CH7_TRG: assert property (o_chan_cfg[2].trig_on |-> o_chan_cfg[2].trig_bus inside {0, 3})
        else $error("channel 7 trigger bus wrong");
    AST_CH8_TRG: assert property (o_chan_cfg[3].trig_on |-> o_chan_cfg[3].trig_bus != 2'h0)
        else $error("channel 8 trigger bus wrong");
    AST_CH9_TRG: assert property (o_chan_cfg[4].trig_on |-> o_chan_cfg[4].trig_bus inside {1, 3})
        else $error("channel 9 trigger bus wrong");
    AST_MODE_CODE: assert property (!bad_mode)
        else $error("undefined mode decoded");
    AST_RESET_CLEAR: assert property (!$past(i_rst_b) |-> o_chan_cfg == '0)
        else $error("settings not cleared by reset");
    AST_READ_ANSWER: assert property (s_rd_taken |=> o_s_axi_rvalid && !o_s_axi_arready)
        else $error("read answer late");
endmodule : mode_select_sva
bind timer_channel_mode_select mode_select_sva chk_u (.i_clk, .i_rst_b, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rvalid, .i_clock_bus, .i_ext_clock_pin_1, .i_ext_clock_pin_2,
    .i_event_bus, .o_chan_cfg, .o_count_clock, .o_trigger);

// >>> testbench.sv
// self-checking bench: register access over the lite bus, decode checks
// assumes the checker is bound and the source model drives the buses
`timescale 1ns/10ps
module testbench;
    typedef timer_channel_mode_select_pkg::chan_cfg_t cfg_t;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
    logic [3:0] wstrb = '0, clock_bus, event_bus;
    logic awready, wready, bvalid, arready, rvalid, pin_1, pin_2;
    logic [1:0] bresp, rresp, r;
    cfg_t [4:0] chan_cfg;
    logic [4:0] count_clock, trigger;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;
    event_source_model src_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .o_clock_bus(clock_bus),
        .o_pin_1(pin_1), .o_pin_2(pin_2), .o_event_bus(event_bus));
    timer_channel_mode_select dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .i_clock_bus(clock_bus),
        .i_ext_clock_pin_1(pin_1), .i_ext_clock_pin_2(pin_2), .i_event_bus(event_bus),
        .o_chan_cfg(chan_cfg), .o_count_clock(count_clock), .o_trigger(trigger));
    task automatic wr(input logic [31:0] a, input logic [7:0] v, input logic [3:0] s);
        @(posedge i_clk);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= a;
        wdata <= {24'h000000, v};
        wstrb <= s;
        do begin
            @(posedge i_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge i_clk);
        {arvalid, rready} <= 2'h3;
        araddr <= a;
        do begin
            @(posedge i_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // compare decoded settings, ignoring fields that the selection leaves unused
    task automatic chk_cfg(input cfg_t got, input cfg_t exp);
        if (got.clk_from_pin === 1'b1) got.clk_bus = '0;
        if (got.trig_on === 1'b0) got.trig_bus = '0;
        chk({23'h0, got}, {23'h0, exp});
    endtask : chk_cfg
    function automatic cfg_t dec(input int k, input logic [7:0] b);
        cfg_t c = '0;
        c.mode = timer_channel_mode_select_pkg::mode_t'((b[2:1] == 2'b11) ? 3'h6 : b[2:0]);
        c.clk_from_pin = (k < 2) && !b[7];
        c.clk_bus = c.clk_from_pin ? 2'h0 : ((k == 3) ? b[7:6] : b[6:5]);
        c.trig_on = (k == 0) ? (b[4] && b[3]) : (k == 3) ? (b[5] && b[4:3] != 2'h0) : b[4];
        c.trig_bus = (k == 0) ? 2'h3 : (k == 1) ? {1'b1, b[3]} : (k == 3) ? b[4:3] :
            b[3] ? 2'h3 : ((k == 2) ? 2'h0 : 2'h1);
        if (!c.trig_on) c.trig_bus = '0;
        return c;
    endfunction : dec
    function automatic logic [31:0] ad(input int k);
        return {timer_channel_mode_select_pkg::REG_IDX[k][29:0], 2'b00};
    endfunction : ad
    task automatic wrap_up();
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // hang guard
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            rd(ad(k));
            chk(d, 32'h00000000);
            chk({30'h0, r}, {30'h0, timer_channel_mode_select_pkg::RESP_OKAY});
            // a cleared clock field is code 000, which picks the pin on ch5 and ch6
            chk_cfg(chan_cfg[k], dec(k, 8'h00));
        end
        // counters are idle throughout, so modes may change freely
        for (int k = 0; k < 5; k++) begin
            for (int v = 0; v < 256; v++) begin
                wr(ad(k), v[7:0], 4'hF);
                chk({30'h0, r}, {30'h0, timer_channel_mode_select_pkg::RESP_OKAY});
                rd(ad(k));
                chk(d, {24'h0, v[7:0] & ((k == 2 || k == 4) ? 8'h7F : 8'hFF)});
                chk_cfg(chan_cfg[k], dec(k, v[7:0]));
            end
        end
        wr(ad(0), 8'h55, 4'h0);
        rd(ad(0));
        chk(d, 32'h000000FF);
        wr(32'h00000000, 8'hA5, 4'hF);
        chk({30'h0, r}, {30'h0, timer_channel_mode_select_pkg::RESP_SLVERR});
        rd(32'h00000000);
        chk(d, 32'h00000000);
        chk({30'h0, r}, {30'h0, timer_channel_mode_select_pkg::RESP_SLVERR});
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(ad(3));
        chk(d, 32'h00000000);
        chk_cfg(chan_cfg[3], dec(3, 8'h00));
        chk_cfg(chan_cfg[0], dec(0, 8'h00));
        wrap_up();
    end
endmodule : testbench

// >>> timer_channel_mode_select.sv
// clock, trigger and mode selection for timer channels 5 to 9
// assumes an AXI4-Lite master that keeps one write and one read in flight
// and counters elsewhere that consume the decoded selections
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module timer_channel_mode_select (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // axi4-lite write address
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_awaddr,
    // axi4-lite write data
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    // axi4-lite write response
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    // axi4-lite read address
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [31:0] i_s_axi_araddr,
    // axi4-lite read data
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    // clock and event sources
    input wire logic [3:0] i_clock_bus,
    input wire logic i_ext_clock_pin_1,
    input wire logic i_ext_clock_pin_2,
    input wire logic [3:0] i_event_bus,
    // decoded selections, slot 0 is channel 5
    output timer_channel_mode_select_pkg::chan_cfg_t [4:0] o_chan_cfg,
    output logic [4:0] o_count_clock,
    output logic [4:0] o_trigger
);

    // maps a byte address onto a channel slot
    function automatic logic [2:0] reg_slot(input logic [31:0] addr);
        logic [2:0] slot;
        slot = timer_channel_mode_select_pkg::CH_NONE;
        for (int k = 0; k < timer_channel_mode_select_pkg::NUM_CH; k++) begin
            if ({timer_channel_mode_select_pkg::REG_IDX[k][29:0], 2'b00}
                    == {addr[31:2], 2'b00}) begin
                slot = 3'(k);
            end
        end
        return slot;
    endfunction : reg_slot

    // mode code to operating mode
    function automatic timer_channel_mode_select_pkg::mode_t decode_mode(
        input logic [2:0] code
    );
        timer_channel_mode_select_pkg::mode_t m;
        case (code)
            3'h0: m = timer_channel_mode_select_pkg::MODE_SINGLE_SHOT;
            3'h1: m = timer_channel_mode_select_pkg::MODE_DELAYED_SINGLE_SHOT;
            3'h2: m = timer_channel_mode_select_pkg::MODE_CONTINUOUS;
            3'h3: m = timer_channel_mode_select_pkg::MODE_PWM;
            3'h4: m = timer_channel_mode_select_pkg::MODE_MEASURE_CLEAR;
            3'h5: m = timer_channel_mode_select_pkg::MODE_MEASURE_FREE_RUN;
            default: m = timer_channel_mode_select_pkg::MODE_NOISE_PROCESSING;
        endcase
        return m;
    endfunction : decode_mode

    logic aw_hold_reg;
    logic [31:0] aw_addr_reg;
    logic w_hold_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [7:0] ctrl_reg [5];
    logic do_write;
    logic [2:0] wr_slot;
    logic [2:0] rd_slot;
    timer_channel_mode_select_pkg::chan_cfg_t [4:0] cfg_next;
    timer_channel_mode_select_pkg::chan_cfg_t [4:0] cfg_reg;
    logic [4:0] count_clock_reg;
    logic [4:0] trigger_reg;
    logic [4:0] pin_level;

    // handshake outputs
    assign o_s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign o_s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign o_s_axi_arready = !rvalid_reg;
    assign o_s_axi_bvalid = bvalid_reg;
    assign o_s_axi_bresp = bresp_reg;
    assign o_s_axi_rvalid = rvalid_reg;
    assign o_s_axi_rdata = rdata_reg;
    assign o_s_axi_rresp = rresp_reg;

    // write commits once address and data are both held
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_slot = reg_slot(aw_addr_reg);
    assign rd_slot = reg_slot(i_s_axi_araddr);

    // write address capture
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 32'h00000000;
        end else if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= i_s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    // write data capture, only the low byte lane carries register data
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            w_hold_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= i_s_axi_wdata[7:0];
            w_lane0_reg <= i_s_axi_wstrb[0];
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    // write response, slave error for an unmapped address
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= timer_channel_mode_select_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            if (wr_slot == timer_channel_mode_select_pkg::CH_NONE) begin
                bresp_reg <= timer_channel_mode_select_pkg::RESP_SLVERR;
            end else begin
                bresp_reg <= timer_channel_mode_select_pkg::RESP_OKAY;
            end
        end else if (i_s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read path, unmapped addresses read zero with slave error
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= timer_channel_mode_select_pkg::RESP_OKAY;
        end else if (i_s_axi_arvalid && o_s_axi_arready) begin
            rvalid_reg <= 1'b1;
            if (rd_slot == timer_channel_mode_select_pkg::CH_NONE) begin
                rdata_reg <= 32'h00000000;
                rresp_reg <= timer_channel_mode_select_pkg::RESP_SLVERR;
            end else begin
                rdata_reg <= {timer_channel_mode_select_pkg::RDATA_PAD, ctrl_reg[rd_slot]};
                rresp_reg <= timer_channel_mode_select_pkg::RESP_OKAY;
            end
        end else if (i_s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // control bytes, one per channel
    generate
        for (genvar k = 0; k < 5; k++) begin : g_ctrl
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    ctrl_reg[k] <= timer_channel_mode_select_pkg::CTRL_RESET;
                end else if (do_write && w_lane0_reg && wr_slot == 3'(k)) begin
                    // unassigned top bit of ch7 and ch9 is masked to zero
                    ctrl_reg[k] <= w_data_reg & timer_channel_mode_select_pkg::WMASK[k];
                end
            end
        end
    endgenerate

    // field decode for each channel
    always_comb begin
        cfg_next = '0;
        // channel 5
        cfg_next[0].clk_from_pin = !ctrl_reg[0][timer_channel_mode_select_pkg::CKS3_MSB];
        cfg_next[0].clk_bus = ctrl_reg[0][timer_channel_mode_select_pkg::CKS3_LSB +: 2];
        cfg_next[0].trig_on = &ctrl_reg[0][timer_channel_mode_select_pkg::ENS2_MSB:
            timer_channel_mode_select_pkg::ENS2_LSB];
        cfg_next[0].trig_bus = 2'h3;
        // channel 6
        cfg_next[1].clk_from_pin = !ctrl_reg[1][timer_channel_mode_select_pkg::CKS3_MSB];
        cfg_next[1].clk_bus = ctrl_reg[1][timer_channel_mode_select_pkg::CKS3_LSB +: 2];
        cfg_next[1].trig_on = ctrl_reg[1][timer_channel_mode_select_pkg::ENS2_MSB];
        cfg_next[1].trig_bus = {1'b1, ctrl_reg[1][timer_channel_mode_select_pkg::ENS2_LSB]};
        // channel 7
        cfg_next[2].clk_from_pin = 1'b0;
        cfg_next[2].clk_bus = ctrl_reg[2][timer_channel_mode_select_pkg::CKS_LO_MSB:
            timer_channel_mode_select_pkg::CKS_LO_LSB];
        cfg_next[2].trig_on = ctrl_reg[2][timer_channel_mode_select_pkg::ENS2_MSB];
        cfg_next[2].trig_bus = ctrl_reg[2][timer_channel_mode_select_pkg::ENS2_LSB] ?
            2'h3 : 2'h0;
        // channel 8
        cfg_next[3].clk_from_pin = 1'b0;
        cfg_next[3].clk_bus = ctrl_reg[3][timer_channel_mode_select_pkg::CKS_HI_MSB:
            timer_channel_mode_select_pkg::CKS_HI_LSB];
        cfg_next[3].trig_on = ctrl_reg[3][timer_channel_mode_select_pkg::ENS3_MSB]
            && (ctrl_reg[3][timer_channel_mode_select_pkg::ENS3_LSB +: 2] != 2'h0);
        cfg_next[3].trig_bus = ctrl_reg[3][timer_channel_mode_select_pkg::ENS3_LSB +: 2];
        // channel 9
        cfg_next[4].clk_from_pin = 1'b0;
        cfg_next[4].clk_bus = ctrl_reg[4][timer_channel_mode_select_pkg::CKS_LO_MSB:
            timer_channel_mode_select_pkg::CKS_LO_LSB];
        cfg_next[4].trig_on = ctrl_reg[4][timer_channel_mode_select_pkg::ENS2_MSB];
        cfg_next[4].trig_bus = ctrl_reg[4][timer_channel_mode_select_pkg::ENS2_LSB] ?
            2'h3 : 2'h1;
        // mode field is shared in layout by all five channels
        for (int k = 0; k < 5; k++) begin
            cfg_next[k].mode = decode_mode(ctrl_reg[k][timer_channel_mode_select_pkg::MODE_MSB:
                timer_channel_mode_select_pkg::MODE_LSB]);
        end
    end

    // external pin offered to each channel, only ch5 and ch6 have one
    assign pin_level = {3'b000, i_ext_clock_pin_2, i_ext_clock_pin_1};

    // registered selections and source routing per channel
    generate
        for (genvar k = 0; k < 5; k++) begin : g_route
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    cfg_reg[k] <= '0;
                    count_clock_reg[k] <= 1'b0;
                    trigger_reg[k] <= 1'b0;
                end else begin
                    cfg_reg[k] <= cfg_next[k];
                    count_clock_reg[k] <= cfg_next[k].clk_from_pin ? pin_level[k] :
                        i_clock_bus[cfg_next[k].clk_bus];
                    trigger_reg[k] <= cfg_next[k].trig_on &&
                        i_event_bus[cfg_next[k].trig_bus];
                end
            end
        end
    endgenerate

    // outputs
    assign o_chan_cfg = cfg_reg;
    assign o_count_clock = count_clock_reg;
    assign o_trigger = trigger_reg;

endmodule : timer_channel_mode_select

// >>> timer_channel_mode_select_pkg.sv
// constants and types for the channel 5 to 9 mode select block
// assumes a 32-bit AXI4-Lite register bus and byte-wide control registers
package timer_channel_mode_select_pkg;

    localparam int NUM_CH = 5;
    localparam int NUM_BUS = 4;

    // register indices; byte address is four times the index
    localparam logic [31:0] TIMER5_CONTROL_IDX = 32'h0080034B;
    localparam logic [31:0] TIMER6_CONTROL_IDX = 32'h0080036A;
    localparam logic [31:0] TIMER7_CONTROL_IDX = 32'h0080036B;
    localparam logic [31:0] TIMER8_CONTROL_IDX = 32'h0080038A;
    localparam logic [31:0] TIMER9_CONTROL_IDX = 32'h0080038B;
    localparam logic [31:0] REG_IDX [NUM_CH] = '{TIMER5_CONTROL_IDX, TIMER6_CONTROL_IDX,
        TIMER7_CONTROL_IDX, TIMER8_CONTROL_IDX, TIMER9_CONTROL_IDX};

    // channel slots
    localparam logic [2:0] CH5 = 3'h0;
    localparam logic [2:0] CH6 = 3'h1;
    localparam logic [2:0] CH7 = 3'h2;
    localparam logic [2:0] CH8 = 3'h3;
    localparam logic [2:0] CH9 = 3'h4;
    localparam logic [2:0] CH_NONE = 3'h5;

    // reset value and writable bits of each control byte
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] WMASK [NUM_CH] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h7F};

    // field positions inside the byte (first bit of the halfword is bit 7)
    localparam int CKS3_MSB = 7;
    localparam int CKS3_LSB = 5;
    localparam int CKS_HI_MSB = 7;
    localparam int CKS_HI_LSB = 6;
    localparam int CKS_LO_MSB = 6;
    localparam int CKS_LO_LSB = 5;
    localparam int ENS2_MSB = 4;
    localparam int ENS2_LSB = 3;
    localparam int ENS3_MSB = 5;
    localparam int ENS3_LSB = 3;
    localparam int MODE_MSB = 2;
    localparam int MODE_LSB = 0;

    // bus response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [23:0] RDATA_PAD = 24'h000000;

    typedef enum logic [2:0] {
        MODE_SINGLE_SHOT,
        MODE_DELAYED_SINGLE_SHOT,
        MODE_CONTINUOUS,
        MODE_PWM,
        MODE_MEASURE_CLEAR,
        MODE_MEASURE_FREE_RUN,
        MODE_NOISE_PROCESSING
    } mode_t;

    typedef struct packed {
        logic clk_from_pin;
        logic [1:0] clk_bus;
        logic trig_on;
        logic [1:0] trig_bus;
        mode_t mode;
    } chan_cfg_t;

endpackage : timer_channel_mode_select_pkg
